// file: src/lfa_pkg.sv
// Purpose: shared constants for the line fault, alarm simulation and loop-back status block
// Assumes: 32-bit AHB-Lite register words, one register per aligned word
// Notes:   byte address of a register is four times its index
`default_nettype none
package lfa_pkg;
    // register indices
    localparam logic [7:0] IDX_CTRL      = 8'h40;
    localparam logic [7:0] IDX_EVENT     = 8'h41;
    localparam logic [7:0] IDX_LINE_FLT  = 8'h4D;
    localparam logic [7:0] IDX_SIM_STAT  = 8'h4E;
    localparam logic [7:0] IDX_E1_LOOP   = 8'h4F;
    // control register fields
    localparam int CTL_DRS_LSB  = 0;
    localparam int CTL_AUTO_TRISTATE_DISABLE    = 2;
    localparam int CTL_XLT      = 3;
    localparam int CTL_SIM      = 4;
    localparam int CTL_T1       = 5;
    localparam int CTL_PRBS     = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // status field positions
    localparam int LF_SHORT     = 1;
    localparam int LF_OPEN      = 0;
    localparam int SIM_STEP_LSB = 5;
    localparam int LB_DEACT     = 4;
    localparam int LB_ACT       = 3;
    localparam int EV_LINE      = 0;
    localparam int EV_LOOP      = 1;
    // line figures
    localparam int SHORT_PULSES = 3;
    localparam int PROBE_PERIODS = 128;
    localparam int OPEN_ZEROS   = 32;
    localparam logic [1:0] DRS_TERNARY = 2'h0;
    // loop-back detection: window of bits, error limit below 10^-2
    localparam int LB_WIN_BITS  = 1000;
    localparam int LB_ERR_LIMIT = 10;
    localparam int LB_HOLD_MS   = 25;
    localparam int CLK_MHZ      = 250;
    localparam int LB_HOLD_CYC  = LB_HOLD_MS * 1000 * CLK_MHZ;
    // simulation counter amounts, bus transfer type and short detector states
    localparam logic [1:0] FEC_STEP = 2'h2;
    localparam logic [1:0] EBC_STEP = 2'h1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {LS_IDLE, LS_TRISTATE, LS_PROBE} lfa_short_t;
endpackage : lfa_pkg
`default_nettype wire

// file: src/lfa_status.sv
// Purpose: transmit short/open detection, T1 alarm simulation stepping, E1 loop-back flags
// Assumes: line inputs are synchronous strobes on clk_sys_in; AHB-Lite slave, zero wait
// Notes:   status registers are read-only; event register bits clear on write-one
// Summary of operation
// - short of both transmit outputs for 3 pulses sets short flag, tristates unless disabled
// - while short flagged, re-enable outputs every 128 periods, recheck, tristate again
// - short gone: outputs re-enabled, flag cleared; each flag change raises line-fault event
// - short flag only meaningful with ternary driver select equal to zero
// - open flag sets after 32 consecutive zeros sent, clears on first pulse
// - rising open flag raises the same line-fault event
// - output tristate control freezes both short and open flags
// - in T1 each set of simulation enable advances three-bit step counter, bits 7:5
// - eight steps make a full check; counter wraps back to zero
// - steps 1, 2, 5 and 6 force their mapped alarm indications, in T1 mode only
// - signal loss, alarm indication, bit error simulation only while enable is one
// - framing errors count two, E-bit one; async step 2 then sync step 6 counts
// - entering steps 0, 3, 4, 7 resets pending status flags automatically
// - E1 deactivate flag sets after over 25 ms pattern under 10^-2 error rate
// - with PRBS select zero, activate flag sets likewise after 25 ms of pattern
// - time slot 0 excluded from error rate while frame aligned
// - any change of either loop-back flag in E1 mode raises loop-back change event
// - with PRBS select one, activate flag shows PRBS synchroniser state
// - loop-back flags valid only in E1 mode
`default_nettype none
module lfa_status #(
    parameter int HOLD_CYC = lfa_pkg::LB_HOLD_CYC,
    parameter int WIN_BITS = lfa_pkg::LB_WIN_BITS
) (
    input  wire logic        clk_sys_in,
    input  wire logic        rstn_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // transmit line side
    input  wire logic        tx_pulse_period_in,
    input  wire logic        tx_mark_in,
    input  wire logic        line_short_sense_in,
    output logic             tx_drive_en_out,
    // receive side for loop-back detection
    input  wire logic        rx_bit_strobe_in,
    input  wire logic        rx_ts0_in,
    input  wire logic        frame_aligned_in,
    input  wire logic        act_bit_err_in,
    input  wire logic        deact_bit_err_in,
    input  wire logic        prbs_sync_in,
    // alarm simulation
    input  wire logic        framer_sync_in,
    input  wire logic        sim_count_tick_in,
    output logic             force_frame_align_loss_out,
    output logic             force_multiframe_align_loss_out,
    output logic             force_remote_alarm_out,
    output logic             force_signal_loss_out,
    output logic             force_alarm_indication_out,
    output logic             force_bit_error_out,
    output logic      [1:0]  framing_error_add_out,
    output logic      [1:0]  e_bit_error_add_out,
    output logic             status_flag_reset_out,
    output logic             transmit_line_fault_irq_out,
    output logic             loopback_change_irq_out
);
    localparam int PW = $clog2(lfa_pkg::PROBE_PERIODS + 1);
    localparam int OW = $clog2(lfa_pkg::OPEN_ZEROS + 1);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam int WW = $clog2(WIN_BITS + 1);

    // word index decode, shared by read and write paths
    function automatic logic [7:0] reg_idx(input logic [31:0] a);
        reg_idx = a[9:2];
    endfunction : reg_idx

    logic [7:0]         ctrl_reg;
    logic [1:0]         event_reg;
    logic               wr_pend_reg;
    logic [7:0]         wr_idx_reg;
    logic               short_flag_reg;
    logic               open_flag_reg;
    logic [1:0]         short_cnt_reg;
    logic [PW-1:0]      probe_cnt_reg;
    logic [OW-1:0]      zero_cnt_reg;
    lfa_pkg::lfa_short_t short_st_reg;
    logic [2:0]         step_reg;
    logic               sim_en_d_reg;
    logic               async_in_step2_reg;
    logic [1:0]         lb_flag_reg;
    logic               addr_ok;
    logic               wr_event;
    logic               line_evt;
    logic               loop_evt;
    logic               step_adv;
    logic [2:0]         step_next;
    logic               step_clr_next;
    logic [1:0]         lb_det;
    logic               sim_on;
    logic [7:0]         line_flt_word;
    logic [7:0]         sim_word;
    logic [7:0]         loop_word;

    wire [1:0] line_driver_select     = ctrl_reg[lfa_pkg::CTL_DRS_LSB +: 2];
    wire       auto_tristate_disable   = ctrl_reg[lfa_pkg::CTL_AUTO_TRISTATE_DISABLE];
    wire       output_tristate_control     = ctrl_reg[lfa_pkg::CTL_XLT];
    wire       sim_en  = ctrl_reg[lfa_pkg::CTL_SIM];
    wire       t1_mode = ctrl_reg[lfa_pkg::CTL_T1];
    wire       prbs_sel = ctrl_reg[lfa_pkg::CTL_PRBS];
    wire       ternary = (line_driver_select == lfa_pkg::DRS_TERNARY);

    // bus address phase qualifies on hready so a stalled master never double-fires
    assign addr_ok = hsel_in && hready_in && (htrans_in == lfa_pkg::HTRANS_NONSEQ);

    // write data phase: capture address, commit next cycle
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
        end else begin
            wr_pend_reg <= addr_ok && hwrite_in;
            wr_idx_reg  <= reg_idx(haddr_in);
        end
    end

    assign wr_event = wr_pend_reg && (wr_idx_reg == lfa_pkg::IDX_EVENT);

    // control register, the only plain read-write word
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            ctrl_reg <= lfa_pkg::CTRL_RESET;
        end else if (wr_pend_reg && wr_idx_reg == lfa_pkg::IDX_CTRL) begin
            ctrl_reg <= hwdata_in[7:0];
        end
    end

    // status words assembled from flags; unused bits stay zero
    always_comb begin
        line_flt_word = 8'h00;
        sim_word      = 8'h00;
        loop_word     = 8'h00;
        line_flt_word[lfa_pkg::LF_SHORT] = short_flag_reg && ternary;
        line_flt_word[lfa_pkg::LF_OPEN]  = open_flag_reg;
        sim_word[lfa_pkg::SIM_STEP_LSB +: 3] = step_reg;
        loop_word[lfa_pkg::LB_DEACT] = lb_flag_reg[0];
        loop_word[lfa_pkg::LB_ACT]   = lb_flag_reg[1];
    end

    // read data registered at the address phase, reads change nothing
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            hrdata_out <= 32'h0000_0000;
        end else if (addr_ok && !hwrite_in) begin
            case (reg_idx(haddr_in))
                lfa_pkg::IDX_CTRL:     hrdata_out <= {24'h00_0000, ctrl_reg};
                lfa_pkg::IDX_EVENT:    hrdata_out <= {30'h0000_0000, event_reg};
                lfa_pkg::IDX_LINE_FLT: hrdata_out <= {24'h00_0000, line_flt_word};
                lfa_pkg::IDX_SIM_STAT: hrdata_out <= {24'h00_0000, sim_word};
                lfa_pkg::IDX_E1_LOOP:  hrdata_out <= {24'h00_0000, loop_word};
                default:               hrdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // zero wait state, always okay
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end else begin
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end

    // short detection: 3 shorted pulses, then periodic probe every 128 periods
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            short_st_reg   <= lfa_pkg::LS_IDLE;
            short_flag_reg <= 1'b0;
            short_cnt_reg  <= 2'h0;
            probe_cnt_reg  <= '0;
        end else if (output_tristate_control || !ternary) begin
            // frozen under tristate control; not meaningful off the ternary driver
            short_cnt_reg <= 2'h0;
        end else if (tx_pulse_period_in) begin
            case (short_st_reg)
                lfa_pkg::LS_IDLE: begin
                    if (!line_short_sense_in) begin
                        short_cnt_reg <= 2'h0;
                    end else if (short_cnt_reg == 2'(lfa_pkg::SHORT_PULSES - 1)) begin
                        short_flag_reg <= 1'b1;
                        short_st_reg   <= lfa_pkg::LS_TRISTATE;
                        probe_cnt_reg  <= '0;
                    end else begin
                        short_cnt_reg <= short_cnt_reg + 2'h1;
                    end
                end
                lfa_pkg::LS_TRISTATE: begin
                    if (probe_cnt_reg == PW'(lfa_pkg::PROBE_PERIODS - 1)) begin
                        short_st_reg <= lfa_pkg::LS_PROBE;
                    end else begin
                        probe_cnt_reg <= probe_cnt_reg + PW'(1);
                    end
                end
                lfa_pkg::LS_PROBE: begin
                    probe_cnt_reg <= '0;
                    short_cnt_reg <= 2'h0;
                    if (line_short_sense_in) begin
                        short_st_reg <= lfa_pkg::LS_TRISTATE;
                    end else begin
                        short_st_reg   <= lfa_pkg::LS_IDLE;
                        short_flag_reg <= 1'b0;
                    end
                end
                default: short_st_reg <= lfa_pkg::LS_IDLE;
            endcase
        end
    end

    // drivers off in reset, otherwise only while tristated on a short and auto-tristate is allowed
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            tx_drive_en_out <= 1'b0;
        end else begin
            tx_drive_en_out <= !(short_st_reg == lfa_pkg::LS_TRISTATE && !auto_tristate_disable);
        end
    end

    // open detection counts zeros per transmitted period
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            open_flag_reg <= 1'b0;
            zero_cnt_reg  <= '0;
        end else if (!output_tristate_control && tx_pulse_period_in) begin
            if (tx_mark_in) begin
                zero_cnt_reg  <= '0;
                open_flag_reg <= 1'b0;
            end else if (zero_cnt_reg == OW'(lfa_pkg::OPEN_ZEROS - 1)) begin
                open_flag_reg <= 1'b1;
            end else begin
                zero_cnt_reg <= zero_cnt_reg + OW'(1);
            end
        end
    end

    // loop-back detectors: [0] deactivate, [1] activate
    generate
        for (genvar g = 0; g < 2; g++) begin : g_lb
            logic [WW-1:0] win_cnt_reg;
            logic [3:0]    err_cnt_reg;
            logic [HW-1:0] hold_cnt_reg;
            logic          good_reg;
            logic          det_reg;
            wire           err_bit = (g == 0) ? deact_bit_err_in : act_bit_err_in;
            wire           count_bit = rx_bit_strobe_in && !(frame_aligned_in && rx_ts0_in);
            // error rate judged per window; hold timer runs while windows stay good
            always_ff @(posedge clk_sys_in) begin
                if (!rstn_in) begin
                    win_cnt_reg  <= '0;
                    err_cnt_reg  <= 4'h0;
                    hold_cnt_reg <= '0;
                    good_reg     <= 1'b0;
                    det_reg      <= 1'b0;
                end else begin
                    if (count_bit) begin
                        if (win_cnt_reg == WW'(WIN_BITS - 1)) begin
                            win_cnt_reg <= '0;
                            err_cnt_reg <= 4'h0;
                            good_reg    <= (5'(err_cnt_reg) + 5'(err_bit)) < 5'(lfa_pkg::LB_ERR_LIMIT);
                        end else begin
                            win_cnt_reg <= win_cnt_reg + WW'(1);
                            if (err_bit && err_cnt_reg != 4'hF) begin
                                err_cnt_reg <= err_cnt_reg + 4'h1;
                            end
                        end
                    end
                    if (!good_reg) begin
                        hold_cnt_reg <= '0;
                        det_reg      <= 1'b0;
                    end else if (hold_cnt_reg == HW'(HOLD_CYC)) begin
                        det_reg <= 1'b1;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + HW'(1);
                    end
                end
            end
            assign lb_det[g] = det_reg;
        end
    endgenerate

    // flags visible only in E1; activate flag follows prbs sync when selected
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            lb_flag_reg <= 2'h0;
        end else if (t1_mode) begin
            lb_flag_reg <= 2'h0;
        end else begin
            lb_flag_reg[0] <= lb_det[0];
            lb_flag_reg[1] <= prbs_sel ? prbs_sync_in : lb_det[1];
        end
    end

    // events derived from flag changes in their next-state form
    assign line_evt = tx_pulse_period_in && !output_tristate_control && ternary &&
                      ((short_st_reg == lfa_pkg::LS_IDLE && line_short_sense_in &&
                        short_cnt_reg == 2'(lfa_pkg::SHORT_PULSES - 1)) ||
                       (short_st_reg == lfa_pkg::LS_PROBE && !line_short_sense_in))
                   || (tx_pulse_period_in && !output_tristate_control && !tx_mark_in && !open_flag_reg &&
                       zero_cnt_reg == OW'(lfa_pkg::OPEN_ZEROS - 1));
    assign loop_evt = !t1_mode &&
                      ((lb_flag_reg[0] != lb_det[0]) ||
                       (lb_flag_reg[1] != (prbs_sel ? prbs_sync_in : lb_det[1])));

    // simulation step counter, stepped on each rising enable in T1
    assign step_adv      = t1_mode && sim_en && !sim_en_d_reg;
    assign step_next     = step_reg + 3'h1;
    assign step_clr_next = step_adv && (step_next == 3'h0 || step_next == 3'h3 ||
                                        step_next == 3'h4 || step_next == 3'h7);

    // event bits: set wins over write-one clear; step entry clears pending
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            event_reg <= 2'h0;
        end else begin
            event_reg[lfa_pkg::EV_LINE] <= line_evt ||
                (event_reg[lfa_pkg::EV_LINE] && !step_clr_next &&
                 !(wr_event && hwdata_in[lfa_pkg::EV_LINE]));
            event_reg[lfa_pkg::EV_LOOP] <= loop_evt ||
                (event_reg[lfa_pkg::EV_LOOP] && !step_clr_next &&
                 !(wr_event && hwdata_in[lfa_pkg::EV_LOOP]));
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            transmit_line_fault_irq_out <= 1'b0;
            loopback_change_irq_out     <= 1'b0;
        end else begin
            transmit_line_fault_irq_out <= event_reg[lfa_pkg::EV_LINE];
            loopback_change_irq_out     <= event_reg[lfa_pkg::EV_LOOP];
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            step_reg           <= 3'h0;
            sim_en_d_reg       <= 1'b0;
            async_in_step2_reg <= 1'b0;
        end else begin
            sim_en_d_reg <= sim_en;
            if (step_adv) begin
                step_reg <= step_next;
                if (step_next == 3'h2) begin
                    async_in_step2_reg <= 1'b0;
                end
            end else if (step_reg == 3'h2 && !framer_sync_in) begin
                async_in_step2_reg <= 1'b1;
            end
        end
    end

    assign sim_on = t1_mode && sim_en;

    // forced indications per step; only in T1 and only while enabled
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            force_frame_align_loss_out      <= 1'b0;
            force_multiframe_align_loss_out <= 1'b0;
            force_remote_alarm_out          <= 1'b0;
            force_signal_loss_out           <= 1'b0;
            force_alarm_indication_out      <= 1'b0;
            force_bit_error_out             <= 1'b0;
            status_flag_reset_out           <= 1'b0;
        end else begin
            force_frame_align_loss_out      <= sim_on && (step_reg == 3'h2 || step_reg == 3'h6);
            force_multiframe_align_loss_out <= sim_on && (step_reg == 3'h2 || step_reg == 3'h6);
            force_remote_alarm_out          <= sim_on && (step_reg == 3'h1 || step_reg == 3'h2 ||
                                                          step_reg == 3'h6);
            force_signal_loss_out           <= sim_on && (step_reg == 3'h1 || step_reg == 3'h2 ||
                                                          step_reg == 3'h5);
            force_alarm_indication_out      <= sim_on && (step_reg == 3'h1 || step_reg == 3'h2 ||
                                                          step_reg == 3'h5 || step_reg == 3'h6);
            force_bit_error_out             <= sim_on && (step_reg == 3'h1 || step_reg == 3'h2 ||
                                                          step_reg == 3'h5);
            status_flag_reset_out           <= step_clr_next;
        end
    end

    // counter increments: step 2 when synchronous, or step 6 if step 2 was not
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            framing_error_add_out <= 2'h0;
            e_bit_error_add_out   <= 2'h0;
        end else if (sim_on && sim_count_tick_in && framer_sync_in &&
                     (step_reg == 3'h2 || (step_reg == 3'h6 && async_in_step2_reg))) begin
            framing_error_add_out <= lfa_pkg::FEC_STEP;
            e_bit_error_add_out   <= lfa_pkg::EBC_STEP;
        end else begin
            framing_error_add_out <= 2'h0;
            e_bit_error_add_out   <= 2'h0;
        end
    end
endmodule : lfa_status
`default_nettype wire

// file: src/lfa_unused_placeholder_removed.sv
// Purpose: none
// Assumes: none
// Notes:   intentionally empty
`default_nettype none
`default_nettype wire

// file: test/lfa_line_model.sv
// Purpose: line side model, period and bit strobes
// Assumes: bench asks for short or mark levels
// Notes:   sense is registered with the period strobe
`default_nettype none
module lfa_line_model (
    input  wire logic clk_in,
    input  wire logic short_req_in,
    input  wire logic mark_req_in,
    output logic      period_out,
    output logic      mark_out,
    output logic      sense_out,
    output logic      bit_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_reg = 2'h0;
    // period every four clocks, bit every two; all outputs change together
    always_ff @(posedge clk_in) begin
        div_reg    <= div_reg + 2'h1;
        period_out <= (div_reg == 2'h3);
        bit_out    <= div_reg[0];
        mark_out   <= mark_req_in;
        sense_out  <= short_req_in;
    end
endmodule : lfa_line_model
`default_nettype wire

// file: test/lfa_status_sva.sv
// Purpose: port level checks of the status block
// Assumes: single clock domain
// Notes:   bound onto every lfa_status instance
`default_nettype none
module lfa_status_sva (
    input wire logic        clk_sys_in,
    input wire logic        rstn_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        tx_pulse_period_in,
    input wire logic        line_short_sense_in,
    input wire logic        tx_drive_en_out,
    input wire logic [1:0]  framing_error_add_out,
    input wire logic [1:0]  e_bit_error_add_out,
    input wire logic        force_frame_align_loss_out,
    input wire logic        force_multiframe_align_loss_out,
    input wire logic        force_signal_loss_out,
    input wire logic        force_alarm_indication_out,
    input wire logic        status_flag_reset_out,
    input wire logic        transmit_line_fault_irq_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!rstn_in);
    upper_zero_a: assert property (hrdata_out[31:8] == 24'h0)
        else $error("reserved read bits set");
    flag_pulse_a: assert property (status_flag_reset_out |=> !status_flag_reset_out)
        else $error("flag reset longer than one cycle");
    fec_amount_a: assert property (framing_error_add_out inside {2'h0, 2'h2})
        else $error("framing count amount wrong");
    fec_ebc_a: assert property (framing_error_add_out == 2'h2 |-> e_bit_error_add_out == 2'h1)
        else $error("e-bit amount wrong");
    mfa_with_fa_a: assert property (force_multiframe_align_loss_out |-> force_frame_align_loss_out)
        else $error("multiframe loss without frame loss");
    los_with_ais_a: assert property (force_signal_loss_out |-> force_alarm_indication_out)
        else $error("signal loss without alarm indication");
    tristate_cause_a: assert property ($fell(tx_drive_en_out)
        |-> $past(tx_pulse_period_in, 2) && $past(line_short_sense_in, 2))
        else $error("tristate without short");
    fault_irq_a: assert property ($rose(transmit_line_fault_irq_out)
        |-> $past(tx_pulse_period_in) || $past(tx_pulse_period_in, 2))
        else $error("line fault event without period");
endmodule : lfa_status_sva
bind lfa_status lfa_status_sva i_sva (.*);
`default_nettype wire

// file: test/lfa_status_bench.sv
// Purpose: self-checking bench of the status block
// Assumes: zero-wait slave, short hold and window parameters
// Notes:   ports joined by name to same-named bench signals
`default_nettype none
module lfa_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, rstn_in, hsel_in, hwrite_in, hready_in, hreadyout_out, hresp_out;
    logic [31:0] haddr_in, hwdata_in, hrdata_out;
    logic [1:0] htrans_in, framing_error_add_out, e_bit_error_add_out;
    logic [2:0] hsize_in;
    logic tx_pulse_period_in, tx_mark_in, line_short_sense_in, tx_drive_en_out, rx_bit_strobe_in;
    logic rx_ts0_in, frame_aligned_in, act_bit_err_in, deact_bit_err_in, prbs_sync_in, framer_sync_in;
    logic sim_count_tick_in, force_frame_align_loss_out, force_multiframe_align_loss_out;
    logic force_remote_alarm_out, force_signal_loss_out, force_alarm_indication_out, force_bit_error_out;
    logic status_flag_reset_out, transmit_line_fault_irq_out, loopback_change_irq_out, short_req, mark_req;
    int   miscompares, n_compared;
    assign hready_in = hreadyout_out;
    lfa_status #(.HOLD_CYC(50), .WIN_BITS(20)) i_dut (.*);
    lfa_line_model i_line (.clk_in(clk_sys_in), .short_req_in(short_req), .mark_req_in(mark_req),
        .period_out(tx_pulse_period_in), .mark_out(tx_mark_in), .sense_out(line_short_sense_in),
        .bit_out(rx_bit_strobe_in));
    task automatic final_report();
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // bounded wait for hready at a rising edge
    task automatic rdy();
        int n;
        n = 0;
        do begin @(posedge clk_sys_in); n++; end while (hready_in !== 1'b1 && n < 40);
        if (hready_in !== 1'b1) begin miscompares++; final_report(); end
    endtask : rdy
    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk_sys_in);
        hsel_in   <= 1'b1;
        htrans_in <= lfa_pkg::HTRANS_NONSEQ;
        hwrite_in <= w;
        haddr_in  <= {22'h0, idx, 2'h0};
        rdy();
        htrans_in <= 2'h0;
        hsel_in   <= 1'b0;
        hwdata_in <= wd;
        rdy();
        rd = hrdata_out;
    endtask : bus
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 32'h0, d);
        chk(d, exp);
    endtask : rc
    task automatic wr(input logic [7:0] idx, input logic [31:0] v);
        logic [31:0] d;
        bus(1'b1, idx, v, d);
    endtask : wr
    task automatic t_regs();
        rc(8'h4D, 32'h0); rc(8'h4E, 32'h0); rc(8'h4F, 32'h0); rc(8'h10, 32'h0);
        wr(8'h4E, 32'hFF); rc(8'h4E, 32'h0);
    endtask : t_regs
    task automatic t_short();
        short_req <= 1'b1; repeat (80) @(posedge clk_sys_in);
        rc(8'h4D, 32'h2); chk(tx_drive_en_out, 1'b0);
        wr(8'h40, 32'h1); rc(8'h4D, 32'h0); wr(8'h40, 32'h0);
        short_req <= 1'b0; repeat (560) @(posedge clk_sys_in);
        rc(8'h4D, 32'h0); chk(tx_drive_en_out, 1'b1); rc(8'h41, 32'h1);
        chk(transmit_line_fault_irq_out, 1'b1); wr(8'h41, 32'h3);
    endtask : t_short
    task automatic t_open();
        mark_req <= 1'b0; repeat (160) @(posedge clk_sys_in);
        rc(8'h4D, 32'h1); rc(8'h41, 32'h1); wr(8'h41, 32'h1); wr(8'h40, 32'h8);
        mark_req <= 1'b1; repeat (20) @(posedge clk_sys_in);
        rc(8'h4D, 32'h1); wr(8'h40, 32'h0); repeat (20) @(posedge clk_sys_in);
        rc(8'h4D, 32'h0);
    endtask : t_open
    task automatic t_sim();
        logic [7:0] fa = 8'h44, ra = 8'h46, be = 8'h26;
        for (int i = 1; i <= 8; i++) begin
            wr(8'h40, 32'h20); wr(8'h40, 32'h30);
            rc(8'h4E, 32'((i % 8) << 5));
            chk({force_frame_align_loss_out, force_remote_alarm_out, force_bit_error_out,
                 framing_error_add_out, e_bit_error_add_out}, {fa[i%8], ra[i%8], be[i%8], (i%8 == 2) ? 4'h9 : 4'h0});
            if (i % 8 inside {0, 3, 4, 7}) wr(8'h41, 32'h3);
        end
        wr(8'h40, 32'h0);
    endtask : t_sim
    task automatic t_loop();
        wr(8'h41, 32'h3); {act_bit_err_in, deact_bit_err_in} <= 2'h0; repeat (300) @(posedge clk_sys_in);
        rc(8'h4F, 32'h18); {act_bit_err_in, deact_bit_err_in} <= 2'h3; repeat (100) @(posedge clk_sys_in);
        rc(8'h4F, 32'h0); rc(8'h41, 32'h2); chk({hresp_out, loopback_change_irq_out}, 32'h1);
        wr(8'h40, 32'h40); prbs_sync_in <= 1'b1; rc(8'h4F, 32'h8);
        wr(8'h40, 32'h60); rc(8'h4F, 32'h0); wr(8'h40, 32'h0);
    endtask : t_loop
    initial begin
        clk_sys_in = 1'b0;
        forever #2 clk_sys_in = ~clk_sys_in;
    end
    initial begin
        {rstn_in, hsel_in, hwrite_in, htrans_in, haddr_in, hwdata_in, short_req} = '0;
        {rx_ts0_in, frame_aligned_in, prbs_sync_in} = '0;
        {hsize_in, mark_req, act_bit_err_in, deact_bit_err_in, framer_sync_in, sim_count_tick_in} = {3'h2, 5'h1F};
        miscompares = 0;
        n_compared = 0;
        repeat (12) @(posedge clk_sys_in);
        rstn_in <= 1'b1;
        t_regs(); t_short(); t_open(); t_sim(); t_loop();
        final_report();
    end
endmodule : lfa_status_bench
`default_nettype wire
